// *** ioqc_top.sv ***
// ioqc_top: apb register file and interpreter for queue creation
// assumes an apb master on pclk, completion and fetch sinks on pclk
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`include "ioqc_cfg.svh"
//
// Contract
// - a finished completion-queue creation posts a completion with its status.
// - an identifier in use or out of range fails completion-queue creation with 1h.
// - a zero-based size above the entry capability fails it with 2h.
// - an interrupt vector beyond the supported ones fails it with 8h.
// - submission-queue creation uses only the pointer, dword 10 and dword 11.
// - the pointer is a contiguous base when the flag is one, else a list, page aligned.
// - the queue size is dword 10 bits 31:16, zero based.
// - the identifier is dword 10 bits 15:0 and binds the tail doorbell of that index.
module ioqc_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // completion post to admin completion queue
    output logic cpl_valid,
    input wire logic cpl_ready,
    output logic [15:0] cpl_cid,
    output logic [2:0] cpl_sct,
    output logic [7:0] cpl_sc,
    // command fetch
    output logic fetch_valid,
    input wire logic fetch_ready,
    output logic [`IOQC_QI_W-1:0] fetch_qid,
    output logic [15:0] fetch_idx,
    output logic [63:0] fetch_addr,
    output logic fetch_contig,
    // interrupt
    output logic irq
);
    ioqc_pkg::ioqc_state_t state_q;
    ioqc_pkg::ioqc_state_t state_d;
    logic [31:0] cmd0_q;
    ioqc_pkg::ioqc_addr_t ptr_q;
    logic [31:0] dw10_q;
    logic [31:0] dw11_q;
    ioqc_pkg::ioqc_half_t mqes_q;
    ioqc_pkg::ioqc_half_t maxiv_q;
    logic [3:0] mps_q;
    logic [`IOQC_EV_W-1:0] mask_q;
    logic [`IOQC_QI_W-1:0] qsel_q;
    logic [`IOQC_NQ-1:0] cq_used_q;
    logic [`IOQC_NQ-1:0] sq_used_q;
    logic [`IOQC_NQ-1:0] sq_contig_q;
    logic [`IOQC_NQ-1:0][63:0] sq_base_q;
    logic [`IOQC_NQ-1:0][15:0] sq_size_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic cpl_valid_q;
    logic [15:0] cpl_cid_q;
    logic [2:0] cpl_sct_q;
    logic [7:0] cpl_sc_q;
    logic rd_st_q;
    logic [`IOQC_EV_W-1:0] ev;
    logic [`IOQC_EV_W-1:0] irq_status;

    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a[1:0] == 2'b00) && (a <= `IOQC_A_DOORBELL);
    endfunction

    function automatic logic qid_in_range(input logic [15:0] q);
        qid_in_range = (q != 16'h0000) && (q < `IOQC_QID_LIM);
    endfunction

    // apb phases
    wire setup = psel && !penable;
    wire acc = psel && penable && pready_q;
    wire wr = acc && pwrite && reg_hit(paddr);
    wire idle = (state_q == ioqc_pkg::ST_IDLE);
    // command image locked while a command is in flight
    wire wr_cmd = wr && idle;
    wire wr_go = wr_cmd && (paddr == `IOQC_A_GO) && pwdata[`IOQC_F_GO];
    wire wr_db = wr && (paddr == `IOQC_A_DOORBELL);
    wire rd_st = setup && !pwrite && (paddr == `IOQC_A_IRQ_ST);

    // only dword 10, dword 11 and the cmd0 opcode feed the check
    wire [15:0] c_qid = dw10_q[`IOQC_F_QID];
    wire [15:0] c_size = dw10_q[`IOQC_F_SIZE];
    wire [15:0] c_iv = dw11_q[`IOQC_F_IV];
    wire c_pc = dw11_q[`IOQC_F_PC];
    wire [`IOQC_QI_W-1:0] c_idx = c_qid[`IOQC_QI_W-1:0];
    wire is_cq = (cmd0_q[`IOQC_F_OPC] == `IOQC_OP_CREATE_CQ);
    wire is_sq = (cmd0_q[`IOQC_F_OPC] == `IOQC_OP_CREATE_SQ);
    wire known = is_cq || is_sq;
    wire in_check = (state_q == ioqc_pkg::ST_CHECK);

    // identifier in use or out of range
    wire cq_bad_qid = !qid_in_range(c_qid) || cq_used_q[c_idx];
    wire sq_bad_qid = !qid_in_range(c_qid) || sq_used_q[c_idx];
    wire bad_size = c_size > mqes_q;
    // vector beyond the highest supported one
    wire bad_iv = c_iv > maxiv_q;

    wire [7:0] cq_sc = cq_bad_qid ? `IOQC_SC_BAD_QID :
        bad_size ? `IOQC_SC_SIZE :
        bad_iv ? `IOQC_SC_BAD_IV : `IOQC_SC_OK;
    // vector field is not checked for a submission queue
    wire [7:0] sq_sc = sq_bad_qid ? `IOQC_SC_BAD_QID :
        bad_size ? `IOQC_SC_SIZE : `IOQC_SC_OK;
    wire [7:0] chk_sc = is_cq ? cq_sc : is_sq ? sq_sc : `IOQC_SC_BAD_OP;
    wire chk_ok = known && (chk_sc == `IOQC_SC_OK);
    wire [2:0] chk_sct = (known && !chk_ok) ? `IOQC_SCT_CMD : `IOQC_SCT_GENERIC;

    wire [63:0] page_bytes = `IOQC_PAGE_MIN << mps_q;
    wire [63:0] base_masked = ptr_q & ~(page_bytes - 64'h1);

    // doorbell bound to a created queue of the same index
    wire [15:0] db_qid16 = pwdata[`IOQC_F_DBQID];
    wire [15:0] db_tail = pwdata[`IOQC_F_TAIL];
    wire [`IOQC_QI_W-1:0] db_idx = db_qid16[`IOQC_QI_W-1:0];
    // tail must lie within size plus one entries
    wire db_ok = wr_db && qid_in_range(db_qid16) && sq_used_q[db_idx] &&
        (db_tail <= sq_size_q[db_idx]);
    wire db_bad = wr_db && !db_ok;

    assign ev[`IOQC_EV_OK] = in_check && chk_ok;
    assign ev[`IOQC_EV_ERR] = in_check && !chk_ok;
    assign ev[`IOQC_EV_DB] = db_bad;

    // read selection, registered in the setup cycle
    wire [31:0] rd_mux =
        (paddr == `IOQC_A_CMD0) ? cmd0_q :
        (paddr == `IOQC_A_PTR_LO) ? ptr_q[31:0] :
        (paddr == `IOQC_A_PTR_HI) ? ptr_q[63:32] :
        (paddr == `IOQC_A_DW10) ? dw10_q :
        (paddr == `IOQC_A_DW11) ? dw11_q :
        (paddr == `IOQC_A_LIMITS) ? {maxiv_q, mqes_q} :
        (paddr == `IOQC_A_PAGE) ? {28'h0, mps_q} :
        (paddr == `IOQC_A_RESULT) ? {15'h0, !idle, 5'h0, cpl_sct_q, cpl_sc_q} :
        (paddr == `IOQC_A_IRQ_ST) ? {29'h0, irq_status} :
        (paddr == `IOQC_A_IRQ_MSK) ? {29'h0, mask_q} :
        (paddr == `IOQC_A_QSEL) ? {30'h0, qsel_q} :
        (paddr == `IOQC_A_QBASE_LO) ? sq_base_q[qsel_q][31:0] :
        (paddr == `IOQC_A_QBASE_HI) ? sq_base_q[qsel_q][63:32] :
        (paddr == `IOQC_A_QINFO) ?
            {14'h0, sq_used_q[qsel_q], sq_contig_q[qsel_q], sq_size_q[qsel_q]} :
        32'h0;
    // only the bits that were read are cleared, later events survive
    wire [`IOQC_EV_W-1:0] clr_bits = (rd_st_q && acc) ? prdata_q[`IOQC_EV_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            rd_st_q <= 1'b0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && !reg_hit(paddr);
            rd_st_q <= rd_st;
            if (setup) prdata_q <= pwrite ? 32'h0 : rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd0_q <= 32'h0;
            ptr_q <= 64'h0;
            dw10_q <= 32'h0;
            dw11_q <= 32'h0;
        end else if (wr_cmd) begin
            if (paddr == `IOQC_A_CMD0) cmd0_q <= pwdata;
            if (paddr == `IOQC_A_PTR_LO) ptr_q[31:0] <= pwdata;
            if (paddr == `IOQC_A_PTR_HI) ptr_q[63:32] <= pwdata;
            if (paddr == `IOQC_A_DW10) dw10_q <= pwdata;
            if (paddr == `IOQC_A_DW11) dw11_q <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mqes_q <= `IOQC_RST_MQES;
            maxiv_q <= `IOQC_RST_MAXIV;
            mps_q <= `IOQC_RST_MPS;
            mask_q <= '0;
            qsel_q <= '0;
        end else if (wr) begin
            if (paddr == `IOQC_A_LIMITS) mqes_q <= pwdata[`IOQC_F_MQES];
            if (paddr == `IOQC_A_LIMITS) maxiv_q <= pwdata[`IOQC_F_MAXIV];
            if (paddr == `IOQC_A_PAGE) mps_q <= pwdata[`IOQC_F_MPS];
            if (paddr == `IOQC_A_IRQ_MSK) mask_q <= pwdata[`IOQC_EV_W-1:0];
            if (paddr == `IOQC_A_QSEL) qsel_q <= pwdata[`IOQC_QI_W-1:0];
        end
    end

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ioqc_pkg::ST_IDLE: if (wr_go) state_d = ioqc_pkg::ST_CHECK;
            ioqc_pkg::ST_CHECK: state_d = ioqc_pkg::ST_POST;
            ioqc_pkg::ST_POST: if (cpl_ready) state_d = ioqc_pkg::ST_IDLE;
            default: state_d = ioqc_pkg::ST_IDLE;
        endcase
    end

    // completion held until the sink takes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ioqc_pkg::ST_IDLE;
            cpl_valid_q <= 1'b0;
            cpl_cid_q <= 16'h0000;
            cpl_sct_q <= `IOQC_SCT_GENERIC;
            cpl_sc_q <= `IOQC_SC_OK;
        end else begin
            state_q <= state_d;
            if (in_check) begin
                cpl_valid_q <= 1'b1;
                cpl_cid_q <= cmd0_q[`IOQC_F_CID];
                cpl_sct_q <= chk_sct;
                cpl_sc_q <= chk_sc;
            end else if (cpl_ready) begin
                cpl_valid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cq_used_q <= '0;
            sq_used_q <= '0;
            sq_contig_q <= '0;
            sq_base_q <= '0;
            sq_size_q <= '0;
        end else if (in_check && chk_ok) begin
            if (is_cq) cq_used_q[c_idx] <= 1'b1;
            if (is_sq) begin
                sq_used_q[c_idx] <= 1'b1;
                sq_contig_q[c_idx] <= c_pc;
                sq_base_q[c_idx] <= base_masked;
                sq_size_q[c_idx] <= c_size;
            end
        end
    end

    ioqc_irq u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .ev(ev),
        .clr_bits(clr_bits),
        .mask(mask_q),
        .status(irq_status),
        .irq(irq)
    );

    ioqc_fetch u_fetch (
        .pclk(pclk),
        .presetn(presetn),
        .db_we(db_ok),
        .db_qid(db_idx),
        .db_tail(db_tail),
        .q_used(sq_used_q),
        .q_contig(sq_contig_q),
        .q_base(sq_base_q),
        .q_size(sq_size_q),
        .fetch_valid(fetch_valid),
        .fetch_ready(fetch_ready),
        .fetch_qid(fetch_qid),
        .fetch_idx(fetch_idx),
        .fetch_addr(fetch_addr),
        .fetch_contig(fetch_contig)
    );

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign cpl_valid = cpl_valid_q;
    assign cpl_cid = cpl_cid_q;
    assign cpl_sct = cpl_sct_q;
    assign cpl_sc = cpl_sc_q;

    sequence s_go;
        wr_go;
    endsequence
    sequence s_check;
        state_q == ioqc_pkg::ST_CHECK;
    endsequence
    sequence s_posted;
        cpl_valid_q && (state_q == ioqc_pkg::ST_POST);
    endsequence

    post_done_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        s_go |=> s_check ##1 s_posted)
        else $error("completion not posted");

    qid_fail_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        (in_check && is_cq && cq_bad_qid) |=>
            (cpl_sc_q == `IOQC_SC_BAD_QID) && (cpl_sct_q == `IOQC_SCT_CMD))
        else $error("bad identifier not reported");

    size_fail_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        (in_check && is_cq && !cq_bad_qid && (c_size > mqes_q)) |=>
            (cpl_sc_q == `IOQC_SC_SIZE) && (cpl_sct_q == `IOQC_SCT_CMD))
        else $error("size excess not reported");

    vector_fail_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        (in_check && is_cq && !cq_bad_qid && (c_size <= mqes_q) && (c_iv > maxiv_q)) |=>
            (cpl_sc_q == `IOQC_SC_BAD_IV) && (cpl_sct_q == `IOQC_SCT_CMD) &&
            !cq_used_q[$past(c_idx)])
        else $error("bad vector not reported");

    sq_no_iv_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        (in_check && is_sq && !sq_bad_qid && (c_size <= mqes_q)) |=>
            (cpl_sc_q == `IOQC_SC_OK) ##0 sq_used_q[$past(c_idx)])
        else $error("submission queue wrongly refused");

    base_rec_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        (in_check && is_sq && chk_ok) |=>
            (sq_base_q[$past(c_idx)] == $past(base_masked)) &&
            (sq_contig_q[$past(c_idx)] == $past(c_pc)))
        else $error("queue base not recorded");

    // doorbell beyond size plus one refused
    tail_limit_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_db && sq_used_q[db_idx] && (db_tail > sq_size_q[db_idx])) |=>
            irq_status[`IOQC_EV_DB])
        else $error("tail past queue end accepted");
endmodule

// *** ioqc_cfg.svh ***
// ioqc_cfg.svh: register offsets, field ranges, codes and reset values
// assumes inclusion by bare name from every design file of the block
`ifndef IOQC_CFG_SVH
`define IOQC_CFG_SVH

// queue table
`define IOQC_NQ 4
`define IOQC_QI_W 2
`define IOQC_QID_LIM 16'h0004

// apb map, byte addresses
`define IOQC_A_CMD0 8'h00
`define IOQC_A_PTR_LO 8'h04
`define IOQC_A_PTR_HI 8'h08
`define IOQC_A_DW10 8'h0C
`define IOQC_A_DW11 8'h10
`define IOQC_A_GO 8'h14
`define IOQC_A_LIMITS 8'h18
`define IOQC_A_PAGE 8'h1C
`define IOQC_A_RESULT 8'h20
`define IOQC_A_IRQ_ST 8'h24
`define IOQC_A_IRQ_MSK 8'h28
`define IOQC_A_QSEL 8'h2C
`define IOQC_A_QBASE_LO 8'h30
`define IOQC_A_QBASE_HI 8'h34
`define IOQC_A_QINFO 8'h38
`define IOQC_A_DOORBELL 8'h3C

// fields
`define IOQC_F_OPC 7:0
`define IOQC_F_CID 31:16
`define IOQC_F_SIZE 31:16
`define IOQC_F_QID 15:0
`define IOQC_F_IV 31:16
`define IOQC_F_PC 0
`define IOQC_F_GO 0
`define IOQC_F_MQES 15:0
`define IOQC_F_MAXIV 31:16
`define IOQC_F_MPS 3:0
`define IOQC_F_TAIL 15:0
`define IOQC_F_DBQID 31:16

// opcodes and completion status
`define IOQC_OP_CREATE_SQ 8'h10
`define IOQC_OP_CREATE_CQ 8'h11
`define IOQC_SCT_GENERIC 3'h0
`define IOQC_SCT_CMD 3'h1
`define IOQC_SC_OK 8'h00
`define IOQC_SC_BAD_OP 8'h01
`define IOQC_SC_BAD_QID 8'h01
`define IOQC_SC_SIZE 8'h02
`define IOQC_SC_BAD_IV 8'h08

// reset values
`define IOQC_RST_MQES 16'h00FF
`define IOQC_RST_MAXIV 16'h0000
`define IOQC_RST_MPS 4'h0

// addressing
`define IOQC_PAGE_MIN 64'h0000_0000_0000_1000
`define IOQC_ENTRY_SHIFT 6

// interrupt events
`define IOQC_EV_W 3
`define IOQC_EV_OK 0
`define IOQC_EV_ERR 1
`define IOQC_EV_DB 2

`endif

// *** ioqc_pkg.sv ***
// ioqc_pkg: types shared by the queue-creation block
// assumes ioqc_cfg.svh holds every number
package ioqc_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CHECK = 2'b01,
        ST_POST = 2'b11
    } ioqc_state_t;
    typedef logic [15:0] ioqc_half_t;
    typedef logic [63:0] ioqc_addr_t;
endpackage

// *** ioqc_irq.sv ***
// ioqc_irq: sticky event status, mask and one level interrupt
// assumes events and clears come from logic on pclk
`timescale 1ns/1ps
`include "ioqc_cfg.svh"
module ioqc_irq (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // events and software access
    input wire logic [`IOQC_EV_W-1:0] ev,
    input wire logic [`IOQC_EV_W-1:0] clr_bits,
    input wire logic [`IOQC_EV_W-1:0] mask,
    // state
    output logic [`IOQC_EV_W-1:0] status,
    output logic irq
);
    logic [`IOQC_EV_W-1:0] status_q;
    logic irq_q;
    // set wins over a clear in the same cycle
    wire [`IOQC_EV_W-1:0] status_d = (status_q & ~clr_bits) | ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= '0;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            irq_q <= |(status_d & mask);
        end
    end

    assign status = status_q;
    assign irq = irq_q;

    sticky_set_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        (|ev) |=> ((status_q & $past(ev)) == $past(ev)))
        else $error("event lost in status");
endmodule

// *** ioqc_fetch.sv ***
// ioqc_fetch: per-queue head and tail, issues command fetches
// assumes queue table is stable while a queue is in use
`timescale 1ns/1ps
`include "ioqc_cfg.svh"
module ioqc_fetch (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // doorbell from register file
    input wire logic db_we,
    input wire logic [`IOQC_QI_W-1:0] db_qid,
    input wire logic [15:0] db_tail,
    // queue table
    input wire logic [`IOQC_NQ-1:0] q_used,
    input wire logic [`IOQC_NQ-1:0] q_contig,
    input wire logic [`IOQC_NQ-1:0][63:0] q_base,
    input wire logic [`IOQC_NQ-1:0][15:0] q_size,
    // fetch request
    output logic fetch_valid,
    input wire logic fetch_ready,
    output logic [`IOQC_QI_W-1:0] fetch_qid,
    output logic [15:0] fetch_idx,
    output logic [63:0] fetch_addr,
    output logic fetch_contig
);
    logic [`IOQC_NQ-1:0] pend;
    logic [`IOQC_NQ-1:0][15:0] head_w;
    logic [`IOQC_QI_W-1:0] pick;
    logic any_pend;
    logic valid_q;
    logic [`IOQC_QI_W-1:0] qid_q;
    logic [15:0] idx_q;
    logic [63:0] addr_q;
    logic contig_q;

    wire launch = any_pend && (!valid_q || fetch_ready);
    // entry address in a contiguous queue
    wire [63:0] launch_addr = q_contig[pick] ?
        q_base[pick] + ({48'h0, head_w[pick]} << `IOQC_ENTRY_SHIFT) : q_base[pick];

    // lowest queue first; higher ones wait
    always_comb begin
        pick = '0;
        any_pend = 1'b0;
        for (int i = `IOQC_NQ - 1; i >= 0; i--) begin
            if (pend[i]) begin
                pick = `IOQC_QI_W'(i);
                any_pend = 1'b1;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < `IOQC_NQ; g++) begin : g_q
            logic [15:0] head_q;
            logic [15:0] tail_q;
            wire hit_db = db_we && (db_qid == `IOQC_QI_W'(g));
            wire hit_go = launch && (pick == `IOQC_QI_W'(g));
            wire [15:0] head_nx = (head_q == q_size[g]) ? 16'h0000 : head_q + 16'h0001;
            assign pend[g] = q_used[g] && (head_q != tail_q);
            assign head_w[g] = head_q;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    head_q <= 16'h0000;
                    tail_q <= 16'h0000;
                end else begin
                    if (hit_db) tail_q <= db_tail;
                    if (hit_go) head_q <= head_nx;
                end
            end
            tail_bind_a : assert property (
                @(posedge pclk) disable iff (!presetn)
                hit_db |=> (tail_q == $past(db_tail)))
                else $error("doorbell tail not taken");
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_q <= 1'b0;
            qid_q <= '0;
            idx_q <= 16'h0000;
            addr_q <= 64'h0;
            contig_q <= 1'b0;
        end else if (launch) begin
            valid_q <= 1'b1;
            qid_q <= pick;
            idx_q <= head_w[pick];
            addr_q <= launch_addr;
            contig_q <= q_contig[pick];
        end else if (fetch_ready) begin
            valid_q <= 1'b0;
        end
    end

    assign fetch_valid = valid_q;
    assign fetch_qid = qid_q;
    assign fetch_idx = idx_q;
    assign fetch_addr = addr_q;
    assign fetch_contig = contig_q;

    pend_serve_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        (any_pend && !valid_q) |=> (valid_q && q_used[qid_q]))
        else $error("pending queue not fetched");

    fetch_hold_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        (valid_q && !fetch_ready) |=> (valid_q && $stable(addr_q) && $stable(idx_q)))
        else $error("fetch request dropped");
endmodule

// *** ioqc_host_model.sv ***
// ioqc_host_model: completion and fetch sink on the host side
// assumes handshake outputs of the block are registers on pclk
`timescale 1ns/1ps
module ioqc_host_model (
    // clock and pacing
    input wire logic pclk,
    input wire logic stall,
    // completion and fetch sides
    input wire logic cpl_valid,
    output logic cpl_ready,
    input wire logic [26:0] cpl_word,
    input wire logic fetch_valid,
    output logic fetch_ready,
    input wire logic [81:0] fetch_word,
    // captured results
    output logic [7:0] n_cpl,
    output logic [7:0] n_fetch,
    output logic [26:0] cpl_got,
    output logic [81:0] fetch_got
);
    logic tog;
    initial begin
        tog = 1'b0;
        n_cpl = 8'h00;
        n_fetch = 8'h00;
    end
    // slow mode accepts only every other cycle
    assign cpl_ready = !stall || tog;
    assign fetch_ready = !stall || tog;
    always @(posedge pclk) begin
        tog <= !tog;
        if (cpl_valid && cpl_ready) begin
            n_cpl <= n_cpl + 8'h01;
            cpl_got <= cpl_word;
        end
        if (fetch_valid && fetch_ready) begin
            n_fetch <= n_fetch + 8'h01;
            fetch_got <= fetch_word;
        end
    end
endmodule

// *** io_queue_create_handler_tb.sv ***
// io_queue_create_handler_tb: apb driven checks of queue creation
// assumes the host model as completion and fetch sink on pclk
`timescale 1ns/1ps
`include "ioqc_cfg.svh"
module io_queue_create_handler_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stall, er;
    logic [7:0] paddr, n_cpl, n_fetch;
    logic [31:0] pwdata, prdata, rd;
    logic cpl_valid, cpl_ready, fetch_valid, fetch_ready, fetch_contig, irq;
    logic [15:0] cpl_cid, fetch_idx;
    logic [2:0] cpl_sct;
    logic [7:0] cpl_sc;
    logic [`IOQC_QI_W-1:0] fetch_qid;
    logic [63:0] fetch_addr;
    logic [26:0] cpl_got;
    logic [81:0] fetch_got;
    int err_count, n_checks, cyc;
    always #20 pclk = ~pclk;
    ioqc_top i_ioqc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpl_valid(cpl_valid), .cpl_ready(cpl_ready), .cpl_cid(cpl_cid),
        .cpl_sct(cpl_sct), .cpl_sc(cpl_sc), .fetch_valid(fetch_valid),
        .fetch_ready(fetch_ready), .fetch_qid(fetch_qid), .fetch_idx(fetch_idx),
        .fetch_addr(fetch_addr), .fetch_contig(fetch_contig), .irq(irq));
    ioqc_host_model i_ioqc_host_model (.pclk(pclk), .stall(stall), .cpl_valid(cpl_valid),
        .cpl_ready(cpl_ready), .cpl_word({cpl_cid, cpl_sct, cpl_sc}),
        .fetch_valid(fetch_valid), .fetch_ready(fetch_ready),
        .fetch_word({fetch_qid, fetch_idx, fetch_addr}), .n_cpl(n_cpl), .n_fetch(n_fetch),
        .cpl_got(cpl_got), .fetch_got(fetch_got));
    task test_done;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [81:0] got, input logic [81:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic cmd(input logic [7:0] op, input logic [31:0] d10, d11,
                       input logic [10:0] st);
        logic [7:0] n0;
        n0 = n_cpl;
        apb(1'b1, `IOQC_A_DW10, d10);
        apb(1'b1, `IOQC_A_DW11, d11);
        apb(1'b1, `IOQC_A_CMD0, {16'h0ABC, 8'h00, op});
        apb(1'b1, `IOQC_A_GO, 32'h0000_0001);
        while (n_cpl == n0) @(posedge pclk);
        chk({55'h0, cpl_got}, {55'h0, 16'h0ABC, st});
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            test_done();
        end
    end
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, stall} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        {err_count, n_checks, cyc} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `IOQC_A_LIMITS, 32'h0);
        chk(82'(rd), 82'({`IOQC_RST_MAXIV, `IOQC_RST_MQES}));
        stall <= 1'b1;
        cmd(`IOQC_OP_CREATE_CQ, 32'h0003_0001, 32'h1, {`IOQC_SCT_GENERIC, `IOQC_SC_OK});
        cmd(`IOQC_OP_CREATE_CQ, 32'h0003_0001, 32'h1, {`IOQC_SCT_CMD, `IOQC_SC_BAD_QID});
        cmd(`IOQC_OP_CREATE_CQ, 32'h0003_0004, 32'h1, {`IOQC_SCT_CMD, `IOQC_SC_BAD_QID});
        cmd(`IOQC_OP_CREATE_CQ, 32'h0100_0002, 32'h1, {`IOQC_SCT_CMD, `IOQC_SC_SIZE});
        cmd(`IOQC_OP_CREATE_CQ, 32'h0003_0002, 32'h0001_0001, {`IOQC_SCT_CMD, `IOQC_SC_BAD_IV});
        stall <= 1'b0;
        // page aligned pointer, kept fixed afterwards
        apb(1'b1, `IOQC_A_PTR_LO, 32'h0000_2000);
        apb(1'b1, `IOQC_A_PTR_HI, 32'h0);
        // qid within count, vector field ignored for a submission queue
        cmd(`IOQC_OP_CREATE_SQ, 32'h0001_0002, 32'h0005_0001, {`IOQC_SCT_GENERIC, `IOQC_SC_OK});
        apb(1'b1, `IOQC_A_QSEL, 32'h2);
        apb(1'b0, `IOQC_A_QINFO, 32'h0);
        chk(82'(rd), 82'h3_0001);
        apb(1'b0, `IOQC_A_QBASE_LO, 32'h0);
        chk(82'(rd), 82'h2000);
        apb(1'b1, `IOQC_A_DOORBELL, 32'h0002_0001);
        while (n_fetch == 8'h00) @(posedge pclk);
        chk(fetch_got, {2'h2, 16'h0, 64'h2000});
        chk(82'(fetch_contig), 82'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk(82'({rd, er}), 82'h1);
        chk(82'(irq), 82'h0);
        apb(1'b1, `IOQC_A_IRQ_MSK, 32'h3);
        repeat (2) @(posedge pclk);
        chk(82'(irq), 82'h1);
        apb(1'b0, `IOQC_A_IRQ_ST, 32'h0);
        chk(82'(rd), 82'h3);
        repeat (2) @(posedge pclk);
        chk(82'(irq), 82'h0);
        // tail beyond size plus one entries is refused
        apb(1'b1, `IOQC_A_DOORBELL, 32'h0002_0002);
        apb(1'b0, `IOQC_A_IRQ_ST, 32'h0);
        chk(82'(rd), 82'h4);
        chk(82'(n_fetch), 82'h1);
        test_done();
    end
endmodule
